// file: verilog/rtc_config_interval_alarm.sv
`timescale 1ns/10ps
`default_nettype none

module rtc_config_interval_alarm #(
	parameter int SUB_TICK_CYCLES = rtc_pkg::SUB_TICK_CYCLES
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic       i_por,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic       i_sfr_wr,
	input  wire logic [7:0] i_sfr_wdata,
	output logic      [7:0] o_sfr_rdata,
	output logic            o_rtc_event,
	output logic            o_day_rollover,
	output logic            o_interval_elapsed
);

	// the divider wraps once per 1/128 s, giving the one-cycle tick enable
	localparam int DIV_W = $clog2(SUB_TICK_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SUB_TICK_CYCLES - 1);

	// ------------------------------------------------------------
	// tick divider and timekeeping chain
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic [7:0]       sub_second_counter_q;
	logic [7:0]       sub_second_counter_d;
	logic [7:0]       sec_q;
	logic [7:0]       sec_d;
	logic [7:0]       min_q;
	logic [7:0]       min_d;
	logic [7:0]       hour_q;
	logic [7:0]       hour_d;
	logic             sub_tick;
	logic             sec_tick;
	logic             min_tick;
	logic             hour_tick;
	logic             day_wrap;
	logic [7:0]       hour_last;

	// ------------------------------------------------------------
	// configuration and interval timer state
	// ------------------------------------------------------------
	logic       day_rollover_q;
	logic       day_rollover_d;
	logic       hour_wrap_select_q;
	logic       hour_wrap_select_d;
	logic [1:0] interval_base_select_q;
	logic [1:0] interval_base_select_d;
	logic       single_shot_select_q;
	logic       single_shot_select_d;
	logic       interval_elapsed_q;
	logic       interval_elapsed_d;
	logic       interval_run_enable_q;
	logic       interval_run_enable_d;
	logic [7:0] interval_target_q;
	logic [7:0] interval_target_d;
	logic [7:0] interval_count_q;
	logic [7:0] interval_count_d;
	logic       shot_done_q;
	logic       shot_done_d;
	logic       base_tick;
	logic       interval_hit;
	logic       wr_config;
	logic       wr_target;
	logic [7:0] rdata_d;
	logic       event_d;
	logic [7:0] config_view;

	assign wr_config = i_sfr_wr && (i_sfr_addr == rtc_pkg::ADDR_TIMEKEEPING_CONFIG);

	// the wrap pulses of the divider and the sub-second, seconds and minutes counters double as the interval base ticks
	always_comb begin
		sub_tick  = (div_q == DIV_LAST);
		sec_tick  = sub_tick && (sub_second_counter_q == rtc_pkg::SUB_SECOND_LAST);
		min_tick  = sec_tick && (sec_q == rtc_pkg::SIXTY_LAST);
		hour_tick = min_tick && (min_q == rtc_pkg::SIXTY_LAST);
		hour_last = hour_wrap_select_q ? rtc_pkg::HOUR_LAST_24 : rtc_pkg::HOUR_LAST_256;
		day_wrap  = hour_tick && (hour_q == hour_last);
		div_d     = sub_tick ? '0 : div_q + DIV_W'(1);

		sub_second_counter_d = sub_second_counter_q;
		sec_d  = sec_q;
		min_d  = min_q;
		hour_d = hour_q;
		if (sub_tick) begin
			sub_second_counter_d = sec_tick ? rtc_pkg::RST_COUNTER
				: sub_second_counter_q + 8'h01;
		end
		if (sec_tick) begin
			sec_d = min_tick ? rtc_pkg::RST_COUNTER : sec_q + 8'h01;
		end
		if (min_tick) begin
			min_d = hour_tick ? rtc_pkg::RST_COUNTER : min_q + 8'h01;
		end
		if (hour_tick) begin
			hour_d = day_wrap ? rtc_pkg::RST_COUNTER : hour_q + 8'h01;
		end
	end

	// the time counters keep running through the ordinary reset
	always_ff @(posedge i_core_clk) begin
		if (i_por) begin
			div_q                <= '0;
			sub_second_counter_q <= rtc_pkg::RST_COUNTER;
			sec_q                <= rtc_pkg::RST_COUNTER;
			min_q                <= rtc_pkg::RST_COUNTER;
			hour_q               <= rtc_pkg::RST_COUNTER;
		end else begin
			div_q                <= div_d;
			sub_second_counter_q <= sub_second_counter_d;
			sec_q                <= sec_d;
			min_q                <= min_d;
			hour_q               <= hour_d;
		end
	end

	// ------------------------------------------------------------
	// interval timer
	// ------------------------------------------------------------
	always_comb begin
		unique case (interval_base_select_q)
			rtc_pkg::BASE_SUB_SECOND: base_tick = sub_tick;
			rtc_pkg::BASE_SECOND:     base_tick = sec_tick;
			rtc_pkg::BASE_MINUTE:     base_tick = min_tick;
			rtc_pkg::BASE_HOUR:       base_tick = hour_tick;
		endcase

		interval_hit     = 1'b0;
		interval_count_d = interval_count_q;
		// any configuration write re-arms a finished single shot
		shot_done_d      = shot_done_q && !wr_config;

		if (!interval_run_enable_q) begin
			interval_count_d = rtc_pkg::RST_COUNTER;
			shot_done_d      = 1'b0;
		end else if (base_tick && !shot_done_q) begin
			// the compare wraps, so a target of 0 runs the full 256 counts
			if (interval_count_q + 8'h01 == interval_target_q) begin
				interval_hit     = 1'b1;
				interval_count_d = rtc_pkg::RST_COUNTER;
				shot_done_d      = single_shot_select_q;
			end else begin
				interval_count_d = interval_count_q + 8'h01;
			end
		end
	end

	// single shot state clears with the counter so a new run starts clean
	always_ff @(posedge i_core_clk) begin
		if (i_por || i_rst) begin
			interval_count_q <= rtc_pkg::RST_COUNTER;
			shot_done_q      <= 1'b0;
		end else begin
			interval_count_q <= interval_count_d;
			shot_done_q      <= shot_done_d;
		end
	end

	// ------------------------------------------------------------
	// configuration register
	// ------------------------------------------------------------
	assign wr_target = i_sfr_wr && (i_sfr_addr == rtc_pkg::ADDR_INTERVAL_TARGET);

	// the time counters ignore writes: their unlock path lies outside this block
	always_comb begin
		hour_wrap_select_d     = hour_wrap_select_q;
		interval_base_select_d = interval_base_select_q;
		single_shot_select_d   = single_shot_select_q;
		interval_run_enable_d  = interval_run_enable_q;
		interval_target_d      = interval_target_q;
		if (wr_config) begin
			hour_wrap_select_d     = i_sfr_wdata[rtc_pkg::BIT_HOUR_WRAP];
			interval_base_select_d = i_sfr_wdata[rtc_pkg::BIT_BASE_HI:rtc_pkg::BIT_BASE_LO];
			single_shot_select_d   = i_sfr_wdata[rtc_pkg::BIT_SINGLE_SHOT];
			interval_run_enable_d  = i_sfr_wdata[rtc_pkg::BIT_RUN_ENABLE];
		end
		if (wr_target) begin
			interval_target_d = i_sfr_wdata;
		end
	end

	// bit 0 is reserved: its written value is dropped and it always reads 1
	always_ff @(posedge i_core_clk) begin
		if (i_por || i_rst) begin
			interval_base_select_q <= rtc_pkg::RST_BASE;
			single_shot_select_q   <= 1'b0;
			interval_run_enable_q  <= 1'b0;
			interval_target_q      <= rtc_pkg::RST_TARGET;
		end else begin
			interval_base_select_q <= interval_base_select_d;
			single_shot_select_q   <= single_shot_select_d;
			interval_run_enable_q  <= interval_run_enable_d;
			interval_target_q      <= interval_target_d;
		end
	end

	// hour wrap select is kept through the ordinary reset
	// so a watchdog or pin reset never changes how far the hours run
	always_ff @(posedge i_core_clk) begin
		if (i_por) begin
			hour_wrap_select_q <= 1'b0;
		end else if (!i_rst) begin
			hour_wrap_select_q <= hour_wrap_select_d;
		end
	end

	// ------------------------------------------------------------
	// event flags
	// ------------------------------------------------------------
	always_comb begin
		day_rollover_d     = day_rollover_q;
		interval_elapsed_d = interval_elapsed_q;
		if (wr_config && !i_sfr_wdata[rtc_pkg::BIT_DAY_ROLLOVER]) begin
			day_rollover_d = 1'b0;
		end
		if (wr_config && !i_sfr_wdata[rtc_pkg::BIT_INTERVAL_ELAPSED]) begin
			interval_elapsed_d = 1'b0;
		end
		// a hardware set wins over a clearing write in the same cycle
		if (day_wrap) begin
			day_rollover_d = 1'b1;
		end
		if (interval_hit) begin
			interval_elapsed_d = 1'b1;
		end
		// the event pulses on every hit, even while the flag is still high
		event_d = day_wrap || interval_hit;
	end

	// neither flag survives the ordinary reset
	always_ff @(posedge i_core_clk) begin
		if (i_por || i_rst) begin
			day_rollover_q     <= 1'b0;
			interval_elapsed_q <= 1'b0;
		end else begin
			day_rollover_q     <= day_rollover_d;
			interval_elapsed_q <= interval_elapsed_d;
		end
	end

	// ------------------------------------------------------------
	// readback
	// ------------------------------------------------------------
	// reads have no strobe: the data follows the address one cycle later
	always_comb begin
		config_view = {day_rollover_q, hour_wrap_select_q, interval_base_select_q,
			single_shot_select_q, interval_elapsed_q, interval_run_enable_q,
			rtc_pkg::RST_RESERVED};
		unique case (i_sfr_addr)
			rtc_pkg::ADDR_TIMEKEEPING_CONFIG: rdata_d = config_view;
			rtc_pkg::ADDR_SUB_SECOND:         rdata_d = sub_second_counter_q;
			rtc_pkg::ADDR_SECONDS:            rdata_d = sec_q;
			rtc_pkg::ADDR_MINUTES:            rdata_d = min_q;
			rtc_pkg::ADDR_HOURS:              rdata_d = hour_q;
			rtc_pkg::ADDR_INTERVAL_TARGET:    rdata_d = interval_target_q;
			default:                          rdata_d = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// the flag outputs take the next value so they line up with the register bits
	always_ff @(posedge i_core_clk) begin
		if (i_por || i_rst) begin
			o_sfr_rdata        <= 8'h00;
			o_rtc_event        <= 1'b0;
			o_day_rollover     <= 1'b0;
			o_interval_elapsed <= 1'b0;
		end else begin
			o_sfr_rdata        <= rdata_d;
			o_rtc_event        <= event_d;
			o_day_rollover     <= day_rollover_d;
			o_interval_elapsed <= interval_elapsed_d;
		end
	end

endmodule

`default_nettype wire

// file: verilog/rtc_pkg.sv
`default_nettype none
package rtc_pkg;

	// ------------------------------------------------------------
	// register addresses on the special function register port
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMEKEEPING_CONFIG = 8'hA1;
	localparam logic [7:0] ADDR_SUB_SECOND         = 8'hA2;
	localparam logic [7:0] ADDR_SECONDS            = 8'hA3;
	localparam logic [7:0] ADDR_MINUTES            = 8'hA4;
	localparam logic [7:0] ADDR_HOURS              = 8'hA5;
	localparam logic [7:0] ADDR_INTERVAL_TARGET    = 8'hA6;

	// ------------------------------------------------------------
	// timekeeping_config field positions
	// ------------------------------------------------------------
	localparam int BIT_DAY_ROLLOVER     = 7;
	localparam int BIT_HOUR_WRAP        = 6;
	localparam int BIT_BASE_HI          = 5;
	localparam int BIT_BASE_LO          = 4;
	localparam int BIT_SINGLE_SHOT      = 3;
	localparam int BIT_INTERVAL_ELAPSED = 2;
	localparam int BIT_RUN_ENABLE       = 1;
	localparam int BIT_RESERVED         = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic       RST_RESERVED   = 1'b1;
	localparam logic [1:0] RST_BASE       = 2'h0;
	localparam logic [7:0] RST_COUNTER    = 8'h00;
	localparam logic [7:0] RST_TARGET     = 8'h00;

	// ------------------------------------------------------------
	// interval time base codes
	// ------------------------------------------------------------
	localparam logic [1:0] BASE_SUB_SECOND = 2'h0;
	localparam logic [1:0] BASE_SECOND     = 2'h1;
	localparam logic [1:0] BASE_MINUTE     = 2'h2;
	localparam logic [1:0] BASE_HOUR       = 2'h3;

	// ------------------------------------------------------------
	// counter limits
	// ------------------------------------------------------------
	localparam logic [7:0] SUB_SECOND_LAST = 8'h7F;
	localparam logic [7:0] SIXTY_LAST      = 8'h3B;
	localparam logic [7:0] HOUR_LAST_24    = 8'h17;
	localparam logic [7:0] HOUR_LAST_256   = 8'hFF;

	// ------------------------------------------------------------
	// timing: one sub-second tick is 1/128 s
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int SUB_TICK_NS    = 7812500;
	localparam int SUB_TICK_CYCLES = SUB_TICK_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// file: verification/rtc_config_interval_alarm_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_config_interval_alarm_asserts (
	input wire logic       i_core_clk,
	input wire logic       i_rst,
	input wire logic       i_por,
	input wire logic [7:0] i_sfr_addr,
	input wire logic       i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic       o_rtc_event,
	input wire logic       o_day_rollover,
	input wire logic       o_interval_elapsed
);
	// ----------------
	// shadow of the software-written bits
	// ----------------
	logic [7:0] cfg_q;
	logic       cw;
	assign cw = i_sfr_wr && (i_sfr_addr == rtc_pkg::ADDR_TIMEKEEPING_CONFIG);
	// bit 6 survives the ordinary reset, so the mask keeps it
	always_ff @(posedge i_core_clk) begin
		if (i_por)
			cfg_q <= 8'h00;
		else if (i_rst)
			cfg_q <= cfg_q & 8'h40;
		else if (cw)
			cfg_q <= i_sfr_wdata & 8'h7A;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst || i_por);
	sequence s_idle3;
		!cfg_q[1] [*3];
	endsequence
	property p_mirror;
		i_sfr_addr == rtc_pkg::ADDR_TIMEKEEPING_CONFIG |=>
			(o_sfr_rdata & 8'h7B) == ($past(cfg_q) | 8'h01);
	endproperty
	property p_alarm_evt;
		$rose(o_interval_elapsed) |-> o_rtc_event;
	endproperty
	property p_day_evt;
		$rose(o_day_rollover) |-> o_rtc_event;
	endproperty
	property p_alarm_clr;
		cw && !i_sfr_wdata[2] |=> !o_interval_elapsed || o_rtc_event;
	endproperty
	property p_day_clr;
		cw && !i_sfr_wdata[7] |=> !o_day_rollover || o_rtc_event;
	endproperty
	property p_alarm_hold;
		o_interval_elapsed && !(cw && !i_sfr_wdata[2]) |=> o_interval_elapsed;
	endproperty
	property p_day_hold;
		o_day_rollover && !(cw && !i_sfr_wdata[7]) |=> o_day_rollover;
	endproperty
	property p_idle;
		s_idle3 |-> !$rose(o_interval_elapsed);
	endproperty
	a_mirror: assert property (p_mirror) else $error("config readback wrong");
	a_alarm_evt: assert property (p_alarm_evt) else $error("alarm without event");
	a_day_evt: assert property (p_day_evt) else $error("rollover without event");
	a_alarm_clr: assert property (p_alarm_clr) else $error("alarm not cleared");
	a_day_clr: assert property (p_day_clr) else $error("rollover not cleared");
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
	a_day_hold: assert property (p_day_hold) else $error("rollover dropped");
	a_idle: assert property (p_idle) else $error("alarm while disabled");
endmodule
bind rtc_config_interval_alarm rtc_config_interval_alarm_asserts u_chk (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_por(i_por), .i_sfr_addr(i_sfr_addr),
	.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
	.o_rtc_event(o_rtc_event), .o_day_rollover(o_day_rollover),
	.o_interval_elapsed(o_interval_elapsed));
`default_nettype wire

// file: verification/test_rtc_config_interval_alarm.sv
`timescale 1ns/10ps
`default_nettype none
module test_rtc_config_interval_alarm;
	localparam int         TICK = 4;
	localparam logic [7:0] A_CFG = rtc_pkg::ADDR_TIMEKEEPING_CONFIG;
	localparam logic [7:0] A_TGT = rtc_pkg::ADDR_INTERVAL_TARGET;
	logic       i_core_clk, i_rst, i_por, i_sfr_wr;
	logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
	logic       o_rtc_event, o_day_rollover, o_interval_elapsed;
	int         n_fail, checks_done, n, per;
	rtc_config_interval_alarm #(.SUB_TICK_CYCLES(TICK)) dut (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_por(i_por), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
		.o_rtc_event(o_rtc_event), .o_day_rollover(o_day_rollover),
		.o_interval_elapsed(o_interval_elapsed));
	always #50 i_core_clk = ~i_core_clk;
	// ----------------
	// access and check tasks
	// ----------------
	task automatic report_and_stop;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(posedge i_core_clk);
		#1;
		i_sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		#1;
		i_sfr_addr = a;
		@(posedge i_core_clk);
		#1;
		check({24'h0, o_sfr_rdata}, {24'h0, e});
	endtask
	task automatic pulse(input bit por);
		@(posedge i_core_clk);
		#1;
		if (por) i_por = 1'b1; else i_rst = 1'b1;
		@(posedge i_core_clk);
		#1;
		i_por = 1'b0;
		i_rst = 1'b0;
	endtask
	// a bound that runs out ends the run as a failure
	task automatic wait_evt(input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			cnt++;
		end while (o_rtc_event !== 1'b1 && cnt < lim);
		if (o_rtc_event !== 1'b1) begin
			$display("[ERR] %0t timeout waiting for an event", $time);
			n_fail++;
			report_and_stop();
		end
	endtask
	task automatic count_evt(input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(posedge i_core_clk);
			#1;
			if (o_rtc_event === 1'b1) cnt++;
		end
	endtask
	// ----------------
	// main sequence
	// ----------------
	initial begin
		{i_core_clk, i_sfr_wr, i_sfr_addr, i_sfr_wdata} = '0;
		{i_rst, i_por} = 2'b11;
		{n_fail, checks_done} = '0;
		repeat (6) @(posedge i_core_clk);
		#1;
		{i_rst, i_por} = 2'b00;
		rd(A_CFG, 8'h01);
		rd(A_TGT, 8'h00);
		rd(8'h7F, 8'h00);
		wr(A_CFG, 8'hC6);
		rd(A_CFG, 8'h43);
		pulse(1'b0);
		rd(A_CFG, 8'h41);
		pulse(1'b1);
		rd(A_CFG, 8'h01);
		wr(A_TGT, 8'h03);
		wr(A_CFG, 8'h03);
		wait_evt(40, n);
		check({31'h0, o_interval_elapsed}, 32'h1);
		rd(A_CFG, 8'h07);
		wr(A_CFG, 8'h03);
		count_evt(48, n);
		check(n, 32'h4);
		wr(A_CFG, 8'h0B);
		count_evt(48, n);
		check(n, 32'h1);
		wr(A_CFG, 8'h01);
		count_evt(48, n);
		check(n, 32'h0);
		check({31'h0, o_interval_elapsed}, 32'h0);
		// one event per base tick with target 1; gap between events is the tick
		for (int b = 0; b < 3; b++) begin
			per = (b == 0) ? TICK : (b == 1) ? TICK * 128 : TICK * 128 * 60;
			wr(A_TGT, 8'h01);
			wr(A_CFG, {2'b00, b[1:0], 4'h3});
			wait_evt(70000, n);
			wait_evt(70000, n);
			check(n, per);
		end
		// the second minute event has just moved the chain to 0:02:00:00
		rd(rtc_pkg::ADDR_SUB_SECOND, 8'h00);
		rd(rtc_pkg::ADDR_SECONDS, 8'h00);
		rd(rtc_pkg::ADDR_MINUTES, 8'h02);
		rd(rtc_pkg::ADDR_HOURS, 8'h00);
		check({31'h0, o_day_rollover}, 32'h0);
		// hour base: no tick can come within this short window
		wr(A_CFG, 8'h33);
		rd(A_CFG, 8'h33);
		count_evt(48, n);
		check(n, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
